// File: hdl/keypad_wake_interrupt.sv
// Overview of operation
// R01: Eight keypad inputs, each enabled or disabled independently.
// R02: An enabled keypad pin has its pull-up on regardless of port pull-up bits.
// R03: Latch request when an enabled pin falls after all enabled pins were high.
// R04: Edge mode: a fall is ignored while another enabled pin is low.
// R05: Level mode: request stays while any enabled pin is low.
// R06: Level mode: clears after acknowledge and all pins high, either order.
// R07: Acknowledge comes from vector fetch or software writing the acknowledge bit.
// R08: Acknowledge does not block later edges; a new fall latches again.
// R09: Unmasked request makes CPU fetch the keypad vector pair.
// R10: Edge mode: acknowledge clears the latch at once regardless of pins.
// R11: Reset clears request and sensitivity bit even with a pin low.
// R12: Read-only pending flag shows request, independent of mask; reset clears.
// R13: Acknowledge bit is write-only, reads zero, stores nothing.
// R14: Mask bit set stops requests reaching the CPU; reset clears it.
// R15: Sensitivity bit: 1 edges plus levels, 0 edges only.
// R16: Pin-enable bit 1 enables its pin; reset clears the register.
// R17: Keypad enable forces the pin to input, overriding direction.
// R18: Logic runs in wait and stop; unmasked request wakes the processor.
// R19: In break, software acknowledge ignored unless break-clear enabled.
// R20: Software should mask, enable, acknowledge, then unmask.
// R21: Software may alternatively drive pins high as outputs first.
// R22: Keypad input six usable only with RC oscillator and pin-six enable set.
// R23: Synchronise pins, AND enabled pins, detect its falling edge.
`timescale 1ns/1ps
`default_nettype none
module keypad_wake_interrupt
	import kwi_pkg::*;
#(
	parameter int NPINS = KWI_NPINS
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [3:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic [NPINS-1:0] keypadInputs,
	input  wire logic [NPINS-1:0] portDirectionBits,
	input  wire logic [NPINS-1:0] portPullupEnable,
	input  wire logic             vectorFetch,
	input  wire logic             breakState,
	output logic                  cpuIrq,
	output logic                  wakeRequest,
	output logic      [NPINS-1:0] pullupOn,
	output logic      [NPINS-1:0] directionOut
);
	//--------------------------------------------------------------
	// Bus slave
	//--------------------------------------------------------------
	kwi_avl_req_t req;
	logic         accept;
	logic         acceptWrite;
	logic         waitComb;

	always_comb begin
		req.address = avs_address;
		req.read = avs_read;
		req.write = avs_write;
		req.writedata = avs_writedata;
		req.byteenable = avs_byteenable;
	end

	kwi_avl_slave u_slave (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.req         (req),
		.waitrequest (waitComb),
		.accept      (accept),
		.acceptWrite (acceptWrite)
	);

	// Registered answer: low only in the cycle in which a request is taken,
	// high while idle, so a held request always sees one wait state
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !waitComb;
		end
	end

	//--------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------
	logic [NPINS-1:0] pinEnable;
	logic             sensitivity;
	logic             keypadMask;
	logic             oscSelect;
	logic             pinSixEn;
	logic             breakClearEn;
	logic             wrLow;
	logic             wrStatus;
	logic             wrEnable;
	logic             wrConfig;

	always_comb begin
		wrLow = acceptWrite && avs_byteenable[0];
		wrStatus = wrLow && (avs_address == KWI_OFS_STATUS_CONTROL);
		wrEnable = wrLow && (avs_address == KWI_OFS_PIN_ENABLE);
		wrConfig = wrLow && (avs_address == KWI_OFS_PORT_CONFIG);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pinEnable <= NPINS'(KWI_RST_ENABLE); // R16
		end else if (wrEnable) begin
			pinEnable <= avs_writedata[NPINS-1:0]; // R01 R16
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sensitivity <= 1'b0; // R11
			keypadMask <= 1'b0; // R14
		end else if (wrStatus) begin
			sensitivity <= avs_writedata[KWI_BIT_SENSITIVITY]; // R15
			keypadMask <= avs_writedata[KWI_BIT_MASK];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			oscSelect <= KWI_RST_PORTCFG[KWI_BIT_OSC_SELECT];
			pinSixEn <= KWI_RST_PORTCFG[KWI_BIT_PIN_SIX_EN];
			breakClearEn <= KWI_RST_PORTCFG[KWI_BIT_BREAK_CLEAR];
		end else if (wrConfig) begin
			oscSelect <= avs_writedata[KWI_BIT_OSC_SELECT];
			pinSixEn <= avs_writedata[KWI_BIT_PIN_SIX_EN];
			breakClearEn <= avs_writedata[KWI_BIT_BREAK_CLEAR];
		end
	end

	//--------------------------------------------------------------
	// Pin qualification and edge detect
	//--------------------------------------------------------------
	logic [NPINS-1:0] pinSync;
	logic [NPINS-1:0] effEnable;
	logic             allHigh;
	logic             allHighPrev;
	logic             fallEvent;
	logic             anyLow;

	kwi_sync #(.WIDTH(NPINS)) u_sync (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.async  (keypadInputs),
		.synced (pinSync)
	);

	always_comb begin
		effEnable = pinEnable;
		// RC oscillator is select value 0; otherwise pin six is the crystal
		if (oscSelect || !pinSixEn) begin
			effEnable[KWI_PIN_SIX] = 1'b0; // R22
		end
		allHigh = &(pinSync | ~effEnable); // R23
		anyLow = !allHigh;
		// One AND of all enabled pins: a fall while another is low is no event
		fallEvent = allHighPrev && !allHigh; // R03 R04
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			allHighPrev <= 1'b1;
		end else begin
			allHighPrev <= allHigh; // R23
		end
	end

	//--------------------------------------------------------------
	// Request latch
	//--------------------------------------------------------------
	logic swAck;
	logic ack;
	logic latch;
	logic request;

	always_comb begin
		swAck = wrStatus && avs_writedata[KWI_BIT_ACK] && (!breakState || breakClearEn); // R19
		ack = swAck || vectorFetch; // R07
	end

	// A new fall wins over a simultaneous acknowledge so it is not lost
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			latch <= 1'b0; // R11
		end else if (fallEvent) begin
			latch <= 1'b1; // R03 R08
		end else if (ack) begin
			latch <= 1'b0; // R10
		end
	end

	// Level mode: the acknowledge clears the latch while the low level keeps
	// the request up, so acknowledge and release may come in either order
	always_comb begin
		// Edge mode uses the latch alone; level mode adds the low level
		request = latch || (sensitivity && anyLow); // R05 R06 R15
	end

	//--------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------
	logic pendingFlag;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pendingFlag <= 1'b0; // R12
			cpuIrq <= 1'b0;
			wakeRequest <= 1'b0;
		end else begin
			pendingFlag <= request; // R12
			cpuIrq <= request && !keypadMask; // R09 R14
			wakeRequest <= request && !keypadMask; // R18
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pullupOn <= '0;
			directionOut <= '0;
		end else begin
			pullupOn <= portPullupEnable | effEnable; // R02
			directionOut <= portDirectionBits & ~effEnable; // R17
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			avs_readdata <= KWI_RDATA_ZERO;
		end else if (waitComb && avs_read) begin
			avs_readdata <= KWI_RDATA_ZERO;
			unique case (avs_address)
				KWI_OFS_STATUS_CONTROL: begin
					avs_readdata[KWI_BIT_SENSITIVITY] <= sensitivity;
					avs_readdata[KWI_BIT_MASK] <= keypadMask;
					avs_readdata[KWI_BIT_ACK] <= 1'b0; // R13
					avs_readdata[KWI_BIT_PENDING] <= pendingFlag; // R12
				end
				KWI_OFS_PIN_ENABLE: begin
					avs_readdata[NPINS-1:0] <= pinEnable;
				end
				KWI_OFS_PORT_CONFIG: begin
					avs_readdata[KWI_BIT_OSC_SELECT] <= oscSelect;
					avs_readdata[KWI_BIT_PIN_SIX_EN] <= pinSixEn;
					avs_readdata[KWI_BIT_BREAK_CLEAR] <= breakClearEn;
				end
				default: begin
					avs_readdata <= KWI_RDATA_ZERO;
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	sequence s_fall;
		fallEvent;
	endsequence

	sequence s_status_read;
		waitComb && avs_read && (avs_address == KWI_OFS_STATUS_CONTROL);
	endsequence

	sequence s_level_release;
		sensitivity && allHigh && !latch;
	endsequence

	sequence s_unmasked;
		request && !keypadMask;
	endsequence

	sequence s_blocked_edge;
		!allHighPrev && !latch;
	endsequence

	sequence s_break_ack;
		breakState && breakClearEn && wrStatus && avs_writedata[KWI_BIT_ACK] && !fallEvent;
	endsequence

	// An acknowledge must not leave the next qualifying fall ignored
	sequence s_ack_then_fall;
		ack ##[1:64] fallEvent;
	endsequence

	a_fall_latches: assert property (@(posedge mclk) disable iff (!rst_n) // R03
		s_fall |=> latch) else $error("fall did not latch");
	a_edge_ack_clears: assert property (@(posedge mclk) disable iff (!rst_n) // R10
		(ack && !fallEvent) |=> !latch) else $error("ack did not clear latch");
	a_level_holds: assert property (@(posedge mclk) disable iff (!rst_n) // R05
		(sensitivity && anyLow) |-> request) else $error("level request dropped");
	a_mask_blocks: assert property (@(posedge mclk) disable iff (!rst_n) // R14
		keypadMask && $stable(keypadMask) |=> !cpuIrq) else $error("masked irq");
	a_pending_tracks: assert property (@(posedge mclk) disable iff (!rst_n) // R12
		request |=> pendingFlag) else $error("pending flag missed");
	a_break_ignored: assert property (@(posedge mclk) disable iff (!rst_n) // R19
		(breakState && !breakClearEn) |-> !swAck) else $error("ack in break");
	a_pin_six_gated: assert property (@(posedge mclk) disable iff (!rst_n) // R22
		oscSelect |-> !effEnable[KWI_PIN_SIX]) else $error("pin six enabled");
	a_enable_input: assert property (@(posedge mclk) disable iff (!rst_n) // R17
		pinEnable[0] && !oscSelect |=> !directionOut[0]) else $error("dir not forced");

	a_reset_clears: assert property (@(posedge mclk) // R11
		!rst_n |=> (!latch && !sensitivity && !cpuIrq)) else $error("reset left state");
	a_level_clears: assert property (@(posedge mclk) disable iff (!rst_n) // R06
		s_level_release |-> !request) else $error("level request stuck");
	a_unmasked_irq: assert property (@(posedge mclk) disable iff (!rst_n) // R09
		s_unmasked |=> cpuIrq) else $error("unmasked request gave no irq");
	a_unmasked_wake: assert property (@(posedge mclk) disable iff (!rst_n) // R18
		s_unmasked |=> wakeRequest) else $error("unmasked request gave no wake");
	a_edge_blocked: assert property (@(posedge mclk) disable iff (!rst_n) // R04
		s_blocked_edge |=> !latch) else $error("fall latched while a pin was low");
	a_edge_only: assert property (@(posedge mclk) disable iff (!rst_n) // R15
		(!sensitivity && !latch) |-> !request) else $error("level seen in edge mode");
	a_any_pin_fall: assert property (@(posedge mclk) disable iff (!rst_n) // R23
		(allHighPrev && |(effEnable & ~pinSync)) |=> latch) else $error("pin fall missed");
	a_new_fall: assert property (@(posedge mclk) disable iff (!rst_n) // R08
		s_ack_then_fall |=> latch) else $error("fall after ack not latched");
	a_break_ack: assert property (@(posedge mclk) disable iff (!rst_n) // R19
		s_break_ack |=> !latch) else $error("enabled ack in break ignored");

	a_ack_reads_zero: assert property (@(posedge mclk) disable iff (!rst_n) // R13
		s_status_read |=> !avs_readdata[KWI_BIT_ACK]) else $error("ack bit read as one");
	a_pending_read: assert property (@(posedge mclk) disable iff (!rst_n) // R12
		s_status_read |=> (avs_readdata[KWI_BIT_PENDING] == $past(pendingFlag)))
		else $error("pending flag read wrong");
	a_enable_write: assert property (@(posedge mclk) disable iff (!rst_n) // R16
		wrEnable |=> (pinEnable == $past(avs_writedata[NPINS-1:0])))
		else $error("pin enable write lost");
	a_mode_write: assert property (@(posedge mclk) disable iff (!rst_n) // R15
		wrStatus |=> (sensitivity == $past(avs_writedata[KWI_BIT_SENSITIVITY])))
		else $error("sensitivity write lost");
	a_mask_write: assert property (@(posedge mclk) disable iff (!rst_n) // R14
		wrStatus |=> (keypadMask == $past(avs_writedata[KWI_BIT_MASK])))
		else $error("mask write lost");
	a_wait_answers: assert property (@(posedge mclk) disable iff (!rst_n) // bus wait state
		accept |-> !avs_waitrequest) else $error("taken access not answered");

	a_pullup_forced: assert property (@(posedge mclk) disable iff (!rst_n) // R02
		(|effEnable) |=> ((pullupOn & $past(effEnable)) == $past(effEnable)))
		else $error("enabled pin without pull-up");
	a_dir_forced: assert property (@(posedge mclk) disable iff (!rst_n) // R17
		(|effEnable) |=> ((directionOut & $past(effEnable)) == '0))
		else $error("enabled pin left as output");
	a_six_needs_enable: assert property (@(posedge mclk) disable iff (!rst_n) // R22
		!pinSixEn |-> !effEnable[KWI_PIN_SIX]) else $error("pin six used while off");
endmodule
`default_nettype wire

// File: include/kwi_pkg.sv
package kwi_pkg;
	localparam int KWI_NPINS = 8;
	localparam int KWI_PIN_SIX = 6;
	// Register byte addresses on the Avalon-MM slave (word aligned)
	localparam logic [3:0] KWI_OFS_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] KWI_OFS_PIN_ENABLE     = 4'h4;
	localparam logic [3:0] KWI_OFS_PORT_CONFIG    = 4'h8;
	// Status/control field positions
	localparam int KWI_BIT_SENSITIVITY = 0;
	localparam int KWI_BIT_MASK        = 1;
	localparam int KWI_BIT_ACK         = 2;
	localparam int KWI_BIT_PENDING     = 3;
	// Port configuration field positions
	localparam int KWI_BIT_OSC_SELECT  = 0;
	localparam int KWI_BIT_PIN_SIX_EN  = 1;
	localparam int KWI_BIT_BREAK_CLEAR = 2;
	// Reset values
	localparam logic [7:0] KWI_RST_ENABLE = 8'h00;
	localparam logic [7:0] KWI_RST_PORTCFG = 8'h00;
	localparam logic [31:0] KWI_RDATA_ZERO = 32'h00000000;
	// Keypad vector location pair, used by the CPU side
	localparam logic [15:0] KWI_VECTOR_HI = 16'hffe0;
	localparam logic [15:0] KWI_VECTOR_LO = 16'hffe1;

	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} kwi_avl_req_t;

	typedef struct packed {
		logic [7:0] pinEnable;
		logic [7:0] portDirection;
		logic [7:0] portPullup;
	} kwi_port_cfg_t;
endpackage

// File: hdl/kwi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module kwi_sync
	import kwi_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async,
	output logic      [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage1;

	// Released pins read high, matching the pull-up at rest
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stage1 <= '1;
			synced <= '1;
		end else begin
			stage1 <= async;
			synced <= stage1;
		end
	end
endmodule
`default_nettype wire

// File: hdl/kwi_avl_slave.sv
`timescale 1ns/1ps
`default_nettype none
module kwi_avl_slave
	import kwi_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire kwi_avl_req_t req,
	output logic              waitrequest,
	output logic              accept,
	output logic              acceptWrite
);
	// One wait state: every access answers on the second edge it is held
	logic pending;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else if (pending) begin
			pending <= 1'b0;
		end else if (req.read || req.write) begin
			pending <= 1'b1;
		end
	end

	always_comb begin
		waitrequest = (req.read || req.write) && !pending;
		accept = pending && (req.read || req.write);
		acceptWrite = pending && req.write;
	end
endmodule
`default_nettype wire

// File: sim/kwi_keys.sv
`timescale 1ns/1ps
`default_nettype none
module kwi_keys
	import kwi_pkg::*;
(
	input  wire logic [KWI_NPINS-1:0] press,
	input  wire logic [KWI_NPINS-1:0] pullupOn,
	input  wire logic [KWI_NPINS-1:0] driveHigh,
	output logic      [KWI_NPINS-1:0] keyLevel
);
	// A pressed key shorts to ground; a pin neither pulled up nor driven high
	// by its port reads low, so enabling it before its pull-up is on gives
	// the false fall that the bring-up order has to clear
	assign keyLevel = ~press & (pullupOn | driveHigh);
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import kwi_pkg::*;
;
	logic        mclk;
	logic        rst_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  keypadInputs;
	logic [7:0]  press;
	logic [7:0]  portDrive;
	logic        vectorFetch;
	logic        breakState;
	logic        cpuIrq;
	logic        wakeRequest;
	logic [7:0]  pullupOn;
	logic [7:0]  directionOut;
	logic [31:0] q;
	int          failures;
	int          tests_run;

	keypad_wake_interrupt dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.keypadInputs(keypadInputs), .portDirectionBits(8'hff), .portPullupEnable(8'h10),
		.vectorFetch(vectorFetch), .breakState(breakState), .cpuIrq(cpuIrq),
		.wakeRequest(wakeRequest), .pullupOn(pullupOn), .directionOut(directionOut));
	kwi_keys keys (.press(press), .pullupOn(pullupOn), .driveHigh(portDrive),
		.keyLevel(keypadInputs));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 40) begin
			failures++;
		end
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ck_stat(input logic [31:0] exp);
		bus(1'b0, KWI_OFS_STATUS_CONTROL, 32'h0);
		chk(q, exp);
	endtask

	task automatic ck_irq(input logic e);
		chk({30'h0, cpuIrq, wakeRequest}, {30'h0, e, e});
	endtask

	// Sync, edge and output stages need about four cycles; eight leaves margin
	task automatic key(input int i, input logic v);
		@(posedge mclk);
		press[i] <= v;
		repeat (8) @(posedge mclk);
	endtask

	task automatic do_reset;
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		press = 8'h00;
		portDrive = 8'h00;
		vectorFetch = 1'b0;
		breakState = 1'b0;
		failures = 0;
		tests_run = 0;
		do_reset();
		// -------------------------------------------------------------
		// Reset values, unmapped place, pin configuration
		// -------------------------------------------------------------
		ck_stat(32'h0);
		bus(1'b0, KWI_OFS_PIN_ENABLE, 32'h0);
		chk(q, {24'h0, KWI_RST_ENABLE});
		bus(1'b1, 4'hc, 32'hff);
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h0);
		ck_irq(1'b0);
		// Masked bring-up keeps charging pull-ups from raising the CPU request
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h2);
		bus(1'b1, KWI_OFS_PIN_ENABLE, 32'h0f);
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h6);
		bus(1'b0, KWI_OFS_PIN_ENABLE, 32'h0);
		chk(q, 32'h0f);
		chk({24'h0, pullupOn}, 32'h1f);
		chk({24'h0, directionOut}, 32'hf0);
		ck_stat(32'h02);
		$display("test config done");
		// -------------------------------------------------------------
		// Edge-only mode
		// -------------------------------------------------------------
		key(0, 1'b1);
		ck_stat(32'h0a);
		ck_irq(1'b0);
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h6);
		ck_stat(32'h02);
		key(1, 1'b1);
		ck_stat(32'h02);
		key(0, 1'b0);
		key(1, 1'b0);
		key(2, 1'b1);
		ck_stat(32'h0a);
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h0);
		ck_stat(32'h08);
		ck_irq(1'b1);
		@(posedge mclk);
		vectorFetch <= 1'b1;
		@(posedge mclk);
		vectorFetch <= 1'b0;
		repeat (4) @(posedge mclk);
		ck_irq(1'b0);
		ck_stat(32'h0);
		key(2, 1'b0);
		$display("test edge done");
		// -------------------------------------------------------------
		// Edge-and-level mode, both clearing orders
		// -------------------------------------------------------------
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h1);
		key(3, 1'b1);
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h5);
		ck_stat(32'h09);
		ck_irq(1'b1);
		key(3, 1'b0);
		ck_stat(32'h01);
		key(3, 1'b1);
		key(3, 1'b0);
		ck_stat(32'h09);
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h5);
		ck_stat(32'h01);
		$display("test level done");
		// -------------------------------------------------------------
		// Break state and pin six gating
		// -------------------------------------------------------------
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h0);
		breakState <= 1'b1;
		key(0, 1'b1);
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h4);
		ck_stat(32'h08);
		bus(1'b1, KWI_OFS_PORT_CONFIG, 32'h4);
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h4);
		ck_stat(32'h0);
		breakState <= 1'b0;
		key(0, 1'b0);
		ck_stat(32'h0);
		bus(1'b1, KWI_OFS_PIN_ENABLE, 32'h40);
		key(6, 1'b1);
		ck_stat(32'h0);
		key(6, 1'b0);
		// Port drives pin six high before it is enabled, so no false fall
		portDrive <= 8'h40;
		bus(1'b1, KWI_OFS_PORT_CONFIG, 32'h3);
		key(6, 1'b1);
		ck_stat(32'h0);
		key(6, 1'b0);
		bus(1'b1, KWI_OFS_PORT_CONFIG, 32'h2);
		ck_stat(32'h0);
		portDrive <= 8'h00;
		key(6, 1'b1);
		ck_stat(32'h08);
		$display("test break done");
		// -------------------------------------------------------------
		// Reset with a key still held in level mode
		// -------------------------------------------------------------
		bus(1'b1, KWI_OFS_STATUS_CONTROL, 32'h1);
		do_reset();
		repeat (4) @(posedge mclk);
		ck_stat(32'h0);
		ck_irq(1'b0);
		$display("test reset done");
		close_out();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
